// ===== design/cfr_core_regs.sv
// Contract
// - Core group decodes at 0x00-0x0B and 0x80-0x8B in every bank.
// - Indirect port zero forwards accesses to memory at pointer zero.
// - Pointer zero clears on power-on; low byte kept, high zeroed otherwise.
// - Pointer one addresses indirect port one; low byte kept on other resets.
// - Unimplemented bits and locations read zero; writes ignored.
`timescale 1ns/100ps
module cfr_core_regs
    import cfr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic soft_rst,
    input wire cfr_req_t req,
    output logic [7:0] rdata,
    output cfr_mem_t mem_req,
    input wire logic [7:0] mem_rdata,
    input wire logic timeout_evt,
    input wire logic sleep_evt,
    input wire logic [7:0] flag_set,
    output logic [14:0] pc,
    output logic [4:0] bank_select,
    output logic [7:0] working_accumulator,
    output logic [7:0] interrupt_control
);

    // Hit on the core group, independent of bank bits
    function automatic logic core_hit(input logic [14:0] a);
        return a[6:0] <= CFR_OFF_LAST;
    endfunction

    logic [7:0] ptr0_lo_q, ptr0_lo_d, ptr0_hi_q, ptr0_hi_d;
    logic [7:0] ptr1_lo_q, ptr1_lo_d, ptr1_hi_q, ptr1_hi_d;
    logic [7:0] status_q, status_d, bsel_q, bsel_d, working_accumulator_q, working_accumulator_d;
    logic [7:0] pcub_q, pcub_d, intc_q, intc_d;
    logic [14:0] pc_q, pc_d;
    logic [7:0] rdata_q, rdata_d;
    logic hit, wr_hit, rd_hit;

    assign hit = req.valid && core_hit(req.addr);
    assign wr_hit = hit && req.wr;
    assign rd_hit = hit && !req.wr;

    // Indirect ports hold no storage: pass straight to memory
    always_comb begin
        mem_req = '0;
        if (hit && req.addr[6:0] == CFR_OFF_IND0) begin
            mem_req.valid = 1'b1;
            mem_req.wr = req.wr;
            mem_req.addr = {ptr0_hi_q, ptr0_lo_q};
            mem_req.wdata = req.wdata;
        end else if (hit && req.addr[6:0] == CFR_OFF_IND1) begin
            mem_req.valid = 1'b1;
            mem_req.wr = req.wr;
            mem_req.addr = {ptr1_hi_q, ptr1_lo_q};
            mem_req.wdata = req.wdata;
        end
    end

    // Register writes and hardware-owned updates
    always_comb begin
        ptr0_lo_d = ptr0_lo_q;
        ptr0_hi_d = ptr0_hi_q;
        ptr1_lo_d = ptr1_lo_q;
        ptr1_hi_d = ptr1_hi_q;
        status_d = status_q;
        bsel_d = bsel_q;
        working_accumulator_d = working_accumulator_q;
        pcub_d = pcub_q;
        intc_d = intc_q;
        pc_d = pc_q;
        if (wr_hit) begin
            unique case (req.addr[6:0])
                CFR_OFF_PCL: pc_d = {pcub_q[6:0], req.wdata};
                // TO and PD are hardware-owned; software writes Z, DC, C only
                CFR_OFF_STATUS: status_d = (status_q & ~CFR_MASK_STATUS_WR)
                    | (req.wdata & CFR_MASK_STATUS_WR);
                CFR_OFF_PTR0_LO: ptr0_lo_d = req.wdata;
                CFR_OFF_PTR0_HI: ptr0_hi_d = req.wdata;
                CFR_OFF_PTR1_LO: ptr1_lo_d = req.wdata;
                CFR_OFF_PTR1_HI: ptr1_hi_d = req.wdata;
                CFR_OFF_BSEL: bsel_d = req.wdata & CFR_MASK_BSEL;
                CFR_OFF_WORKING_ACCUMULATOR: working_accumulator_d = req.wdata;
                CFR_OFF_PCUB: pcub_d = req.wdata & CFR_MASK_PCUB;
                CFR_OFF_INTC: intc_d = req.wdata;
                default: ; // Indirect ports keep no state
            endcase
        end
        // Flag set beats software clear in the same cycle
        intc_d = intc_d | flag_set;
        if (timeout_evt) begin
            status_d[CFR_STATUS_TO] = 1'b0;
        end
        if (sleep_evt) begin
            status_d[CFR_STATUS_PD] = 1'b0;
        end
    end

    // Read mux, registered so data lands one cycle after the request
    always_comb begin
        rdata_d = rdata_q;
        if (req.valid) begin
            rdata_d = 8'h00;
            if (rd_hit) begin
                unique case (req.addr[6:0])
                    CFR_OFF_IND0, CFR_OFF_IND1: rdata_d = mem_rdata;
                    CFR_OFF_PCL: rdata_d = pc_q[7:0];
                    CFR_OFF_STATUS: rdata_d = status_q & CFR_MASK_STATUS;
                    CFR_OFF_PTR0_LO: rdata_d = ptr0_lo_q;
                    CFR_OFF_PTR0_HI: rdata_d = ptr0_hi_q;
                    CFR_OFF_PTR1_LO: rdata_d = ptr1_lo_q;
                    CFR_OFF_PTR1_HI: rdata_d = ptr1_hi_q;
                    CFR_OFF_BSEL: rdata_d = bsel_q;
                    CFR_OFF_WORKING_ACCUMULATOR: rdata_d = working_accumulator_q;
                    CFR_OFF_PCUB: rdata_d = pcub_q;
                    CFR_OFF_INTC: rdata_d = intc_q;
                    default: rdata_d = 8'h00;
                endcase
            end
        end
    end

    // Power-on reset clears all but status (loads TO and PD set); soft reset keeps the retained bytes
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ptr0_lo_q <= CFR_RST_ZERO;
            ptr0_hi_q <= CFR_RST_ZERO;
            ptr1_lo_q <= CFR_RST_ZERO;
            ptr1_hi_q <= CFR_RST_ZERO;
            status_q <= CFR_RST_STATUS;
            bsel_q <= CFR_RST_ZERO;
            working_accumulator_q <= CFR_RST_ZERO;
            pcub_q <= CFR_RST_ZERO;
            intc_q <= CFR_RST_ZERO;
            pc_q <= '0;
            rdata_q <= CFR_RST_ZERO;
        end else if (clk_en) begin
            if (soft_rst) begin
                // Low pointer bytes, working register and status flags survive
                ptr0_hi_q <= CFR_RST_ZERO;
                ptr1_hi_q <= CFR_RST_ZERO;
                bsel_q <= CFR_RST_ZERO;
                pcub_q <= CFR_RST_ZERO;
                intc_q <= CFR_RST_ZERO;
                pc_q <= '0;
                rdata_q <= CFR_RST_ZERO;
            end else begin
                ptr0_lo_q <= ptr0_lo_d;
                ptr0_hi_q <= ptr0_hi_d;
                ptr1_lo_q <= ptr1_lo_d;
                ptr1_hi_q <= ptr1_hi_d;
                status_q <= status_d;
                bsel_q <= bsel_d;
                working_accumulator_q <= working_accumulator_d;
                pcub_q <= pcub_d;
                intc_q <= intc_d;
                pc_q <= pc_d;
                rdata_q <= rdata_d;
            end
        end
    end

    assign rdata = rdata_q;
    assign pc = pc_q;
    assign bank_select = bsel_q[4:0];
    assign working_accumulator = working_accumulator_q;
    assign interrupt_control = intc_q;

endmodule

// ===== shared/cfr_pkg.sv
package cfr_pkg;
    // Core register offsets within the low 7 bits of a data address
    localparam logic [6:0] CFR_OFF_IND0 = 7'h00;
    localparam logic [6:0] CFR_OFF_IND1 = 7'h01;
    localparam logic [6:0] CFR_OFF_PCL = 7'h02;
    localparam logic [6:0] CFR_OFF_STATUS = 7'h03;
    localparam logic [6:0] CFR_OFF_PTR0_LO = 7'h04;
    localparam logic [6:0] CFR_OFF_PTR0_HI = 7'h05;
    localparam logic [6:0] CFR_OFF_PTR1_LO = 7'h06;
    localparam logic [6:0] CFR_OFF_PTR1_HI = 7'h07;
    localparam logic [6:0] CFR_OFF_BSEL = 7'h08;
    localparam logic [6:0] CFR_OFF_WORKING_ACCUMULATOR = 7'h09;
    localparam logic [6:0] CFR_OFF_PCUB = 7'h0A;
    localparam logic [6:0] CFR_OFF_INTC = 7'h0B;
    localparam logic [6:0] CFR_OFF_LAST = 7'h0B;
    // Implemented-bit masks
    localparam logic [7:0] CFR_MASK_STATUS = 8'h1F;
    localparam logic [7:0] CFR_MASK_STATUS_WR = 8'h07;
    localparam logic [7:0] CFR_MASK_BSEL = 8'h1F;
    localparam logic [7:0] CFR_MASK_PCUB = 8'h7F;
    // Status field positions
    localparam int CFR_STATUS_TO = 4;
    localparam int CFR_STATUS_PD = 3;
    // Reset values
    localparam logic [7:0] CFR_RST_ZERO = 8'h00;
    localparam logic [7:0] CFR_RST_STATUS = 8'h18;

    // Core access from the CPU data path
    typedef struct packed {
        logic valid;
        logic wr;
        logic [14:0] addr;
        logic [7:0] wdata;
    } cfr_req_t;

    // Indirect access forwarded to data memory
    typedef struct packed {
        logic valid;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cfr_mem_t;
endpackage

// ===== test/cfr_core_regs_checker.sv
`timescale 1ns/100ps
module cfr_core_regs_checker
    import cfr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic soft_rst,
    input wire cfr_req_t req,
    input wire logic [7:0] rdata,
    input wire cfr_mem_t mem_req,
    input wire logic [7:0] mem_rdata,
    input wire logic [14:0] pc,
    input wire logic [4:0] bank_select,
    input wire logic [7:0] working_accumulator
);
    // Access taken at this edge; bank bits ignored
    wire go = clk_en && !soft_rst && req.valid;
    wire wr = go && req.wr;
    wire [6:0] off = req.addr[6:0];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    a_working_accumulator_any_bank: assert property (wr && off == 7'h09 |=> working_accumulator == $past(req.wdata)) else $error("working_accumulator write lost");
    a_bsel_write: assert property (wr && off == 7'h08 |=> bank_select == $past(req.wdata[4:0])) else $error("bank select write lost");
    a_ind_read: assert property (go && !req.wr && off == 7'h00 |=> rdata == $past(mem_rdata)) else $error("indirect read wrong");
    a_ind_only: assert property (mem_req.valid |-> req.valid && req.addr[6:1] == 6'h00) else $error("stray memory access");
    a_unmapped_zero: assert property (go && !req.wr && off > 7'h0B |=> rdata == 8'h00) else $error("unmapped read not zero");
    a_pc_hold: assert property (!soft_rst && !(wr && off == 7'h02) |=> $stable(pc)) else $error("pc moved");
    a_pc_load: assert property (wr && off == 7'h02 |=> pc[7:0] == $past(req.wdata)) else $error("pc low not loaded");
    a_soft_clear: assert property (clk_en && soft_rst |=> pc == 15'h0000 && bank_select == 5'h00) else $error("soft reset missed");
endmodule
bind cfr_core_regs cfr_core_regs_checker i_chk (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
    .soft_rst(soft_rst), .req(req), .rdata(rdata), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .pc(pc), .bank_select(bank_select), .working_accumulator(working_accumulator));

// ===== test/tb.sv
`timescale 1ns/100ps
module tb;
    import cfr_pkg::*;
    logic sys_clk = 0, arst_n = 0, soft_rst = 0;
    logic clk_en = 1, to_evt = 0, sl_evt = 0;
    logic [7:0] flag_set = 8'h00;
    cfr_req_t req = '0;
    cfr_mem_t mreq;
    logic [7:0] mem_rdata = 8'h00, rdata, wacc, intc, d;
    logic [14:0] pc, pc_m;
    logic [4:0] bsel;
    int n_fail = 0, checks = 0, seed = 32'hF061;
    logic [7:0] m [12];
    cfr_core_regs i_cfr_core_regs (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
        .soft_rst(soft_rst), .req(req), .rdata(rdata), .mem_req(mreq), .mem_rdata(mem_rdata),
        .timeout_evt(to_evt), .sleep_evt(sl_evt), .flag_set(flag_set), .pc(pc),
        .bank_select(bsel),
        .working_accumulator(wacc), .interrupt_control(intc));
    initial forever #5 sys_clk = ~sys_clk;
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // One access in a random bank; indirect address checked while it stands
    task acc(input logic w, input logic [6:0] o, input logic [7:0] v);
        @(posedge sys_clk);
        req <= '{1'b1, w, {8'($random(seed)), o}, v};
        mem_rdata <= 8'($random(seed));
        #1;
        if (o < 2) chk("mem_addr", mreq.addr, {m[2*o+5], m[2*o+4]});
        @(posedge sys_clk);
        req.valid <= 1'b0;
        #1;
    endtask
    // Model of a write, with unimplemented bits dropped
    task mw(input logic [6:0] o, input logic [7:0] v);
        case (o)
            7'h02: begin
                m[2] = v;
                pc_m = {m[10][6:0], v};
            end
            7'h03: m[3] = {m[3][7:3], v[2:0]};
            7'h08: m[8] = v & 8'h1F;
            7'h0A: m[10] = v & 8'h7F;
            default: if (o > 1 && o < 12) m[o] = v;
        endcase
    endtask
    function automatic logic [7:0] ex(input int o);
        return (o < 2) ? mem_rdata : (o > 11) ? 8'h00 : m[o];
    endfunction
    initial begin
        #100000;
        n_fail++;
        tally_and_finish;
    end
    initial begin
        foreach (m[i]) m[i] = 8'h00;
        m[3] = 8'h18;
        pc_m = 15'h0000;
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int o = 0; o < 16; o++) begin
            acc(1'b0, 7'(o), 8'h00);
            chk("reset_value", rdata, ex(o));
        end
        $display("test reset values done");
        // Random writes then readback, reserved places included
        repeat (3) for (int o = 0; o < 16; o++) begin
            d = 8'($random(seed));
            acc(1'b1, 7'(o), d);
            mw(7'(o), d);
            acc(1'b0, 7'(o), 8'h00);
            chk("readback", rdata, ex(o));
            chk("pc", pc, pc_m);
        end
        $display("test readback done");
        @(posedge sys_clk) soft_rst <= 1'b1;
        @(posedge sys_clk) soft_rst <= 1'b0;
        #1;
        m[2] = 8'h00;
        m[5] = 8'h00;
        m[7] = 8'h00;
        m[8] = 8'h00;
        m[10] = 8'h00;
        m[11] = 8'h00;
        pc_m = 15'h0000;
        chk("pc_soft", pc, pc_m);
        for (int o = 2; o < 12; o++) begin
            acc(1'b0, 7'(o), 8'h00);
            chk("soft_reset", rdata, ex(o));
        end
        $display("test soft reset done");
        // Clock enable low: a write must not land
        clk_en <= 1'b0;
        acc(1'b1, 7'h09, ~m[9]);
        clk_en <= 1'b1;
        acc(1'b0, 7'h09, 8'h00);
        chk("freeze", rdata, ex(9));
        // Hardware events: flags set, status bits cleared
        @(posedge sys_clk);
        flag_set <= 8'h05;
        to_evt <= 1'b1;
        sl_evt <= 1'b1;
        @(posedge sys_clk);
        flag_set <= 8'h00;
        to_evt <= 1'b0;
        sl_evt <= 1'b0;
        m[11] = m[11] | 8'h05;
        m[3] = m[3] & 8'hE7;
        acc(1'b0, 7'h0B, 8'h00);
        chk("flag_set", rdata, ex(11));
        acc(1'b0, 7'h03, 8'h00);
        chk("status_evt", rdata, ex(3));
        $display("test freeze and events done");
        tally_and_finish;
    end
endmodule
